//--- verilog/mft_regs.vh
// Register offsets, field positions, reset values and input function codes of the timer.
`ifndef MFT_REGS_VH
`define MFT_REGS_VH
// Byte addresses on the register bus.
`define ADR_CTRL    8'h00
`define ADR_MODE    8'h04
`define ADR_FLAG    8'h08
`define ADR_INCTL   8'h0c
`define ADR_LC0     8'h10
`define ADR_LC1     8'h14
`define ADR_CMP0    8'h18
`define ADR_PSC     8'h1c
`define ADR_COUNT   8'h20
// Control register fields.
`define CT_START    0
`define CT_UPDN     1
`define CT_CLR      2
`define CT_CLRCAP   3
`define CT_CLRMAT   4
`define CT_DIRSTAT  5
`define CT_RUNSTAT  6
// Mode register fields.
`define MD_ONESHOT  0
`define MD_RETRIG   1
`define MD_CAP0     2
`define MD_CAP1     3
`define MD_BIVAL    4
`define MD_CASC     5
// Flag register fields.
`define FL_SOFT0    0
`define FL_SOFT1    1
// Input control register fields.
`define IC_AEDGE    1:0
`define IC_BEDGE    3:2
`define IC_FUNC     7:4
// Reset values.
`define RST_CTRL    8'h00
`define RST_MODE    8'h00
`define RST_INCTL   8'h00
`define RST_WORD    16'h0000
`define RST_PSC     8'h00
// Count limits and the divide-by-three of the internal clock.
`define CNT_ZERO    16'h0000
`define CNT_FULL    16'hffff
`define DIV3_LAST   2'h2
// Input function codes.
`define FN_NONE     4'h0
`define FN_B_TRIG   4'h1
`define FN_A_GATE   4'h2
`define FN_GATE_TRG 4'h3
`define FN_B_CLK    4'h4
`define FN_A_TRIG   4'h5
`define FN_GATE_CLK 4'h6
`define FN_TRIG_TRG 4'h7
`define FN_CLK_UPDN 4'h8
`define FN_DIR_CLK  4'h9
`define FN_TRIG_DIR 4'ha
`define FN_A_DIR    4'hb
`define FN_DISCR    4'hc
`define FN_TRIG_CLK 4'hd
`define FN_CLK_TRIG 4'he
`define FN_TRIG_GT  4'hf
`endif

//--- verilog/mft_core.v
// Multifunction up/down timer with prescaler, reload/capture registers and input pin functions.
`timescale 1ns/100ps
`include "mft_regs.vh"

module mft_core #(
    parameter CW = 16,
    parameter PW = 8
) (
    // Clock and reset.
    input  wire          i_sys_clk,
    input  wire          i_rst_n,
    // Register bus.
    input  wire          psel,
    input  wire          penable,
    input  wire          pwrite,
    input  wire [7:0]    paddr,
    input  wire [31:0]   pwdata,
    output reg  [31:0]   prdata,
    output wire          pready,
    output wire          pslverr,
    // Timer input pins.
    input  wire          i_timer_input_a,
    input  wire          i_timer_input_b,
    // Cascade link between two timers.
    input  wire          i_cascade_tick,
    output reg           o_prescale_tick,
    // Counter state.
    output reg  [CW-1:0] o_count,
    output reg           o_end_of_count
);

    // Software registers and counter state.
    reg [7:0]    timer_control_reg;
    reg [7:0]    timer_mode_reg;
    reg [7:0]    input_control_reg;
    reg [CW-1:0] load_capture_reg_0;
    reg [CW-1:0] load_capture_reg_1;
    reg [CW-1:0] compare_reg_0;
    reg [PW-1:0] psc_val_r;
    reg [PW-1:0] psc_cnt_r;
    reg [CW-1:0] cnt_r;
    reg [1:0]    div3_r;
    reg          halt_r;
    reg          sel_r;
    reg          dir_step_r;
    reg          dir_trig_r;
    reg [2:0]    a_sy_r;
    reg [2:0]    b_sy_r;
    reg          a_lvl_r;
    reg          b_lvl_r;

    wire one_shot_select    = timer_mode_reg[`MD_ONESHOT];
    wire retrig             = timer_mode_reg[`MD_RETRIG];
    wire reg0_capture_select = timer_mode_reg[`MD_CAP0];
    wire reg1_capture_select = timer_mode_reg[`MD_CAP1];
    wire bivalue_select     = timer_mode_reg[`MD_BIVAL];
    wire cascade_select     = timer_mode_reg[`MD_CASC];
    wire soft_direction_bit = timer_control_reg[`CT_UPDN];
    wire clear_on_capture   = timer_control_reg[`CT_CLRCAP];
    wire clear_on_match     = timer_control_reg[`CT_CLRMAT];
    wire [3:0] input_function_code = input_control_reg[`IC_FUNC];
    wire [1:0] input_a_edge_select = input_control_reg[`IC_AEDGE];
    wire [1:0] input_b_edge_select = input_control_reg[`IC_BEDGE];

    // ******************************************************************
    // Pin synchronisers and edge detection.
    // ******************************************************************

    // A level counts once the second and third stages agree.
    wire a_ok   = (a_sy_r[1] == a_sy_r[2]);
    wire b_ok   = (b_sy_r[1] == b_sy_r[2]);
    wire a_rise = a_ok & a_sy_r[2] & ~a_lvl_r;
    wire a_fall = a_ok & ~a_sy_r[2] & a_lvl_r;
    wire b_rise = b_ok & b_sy_r[2] & ~b_lvl_r;
    wire b_fall = b_ok & ~b_sy_r[2] & b_lvl_r;
    // Edge select: bit 0 takes rising edges, bit 1 falling edges.
    wire a_ev = (input_a_edge_select[0] & a_rise) | (input_a_edge_select[1] & a_fall);
    wire b_ev = (input_b_edge_select[0] & b_rise) | (input_b_edge_select[1] & b_fall);

    // Three-stage synchronisers on both pins.
    always @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            a_sy_r  <= 3'h0;
            b_sy_r  <= 3'h0;
            a_lvl_r <= 1'b0;
            b_lvl_r <= 1'b0;
        end
        else
        begin
            a_sy_r <= {a_sy_r[1:0], i_timer_input_a};
            b_sy_r <= {b_sy_r[1:0], i_timer_input_b};
            if (a_ok)
                a_lvl_r <= a_sy_r[2];
            if (b_ok)
                b_lvl_r <= b_sy_r[2];
        end
    end

    // ******************************************************************
    // Input function decode.
    // ******************************************************************

    reg a_trg;
    reg b_trg;
    reg a_gate;
    reg b_gate;
    reg a_clk;
    reg b_clk;

    // Roles of the two pins for each function code.
    always @*
    begin
        a_trg  = 1'b0;
        b_trg  = 1'b0;
        a_gate = 1'b0;
        b_gate = 1'b0;
        a_clk  = 1'b0;
        b_clk  = 1'b0;
        case (input_function_code)
            `FN_B_TRIG:   b_trg = 1'b1;
            `FN_A_GATE:   a_gate = 1'b1;
            `FN_GATE_TRG:
            begin
                a_gate = 1'b1;
                b_trg  = 1'b1;
            end
            `FN_B_CLK:    b_clk = 1'b1;
            `FN_A_TRIG:   a_trg = 1'b1;
            `FN_GATE_CLK:
            begin
                a_gate = 1'b1;
                b_clk  = 1'b1;
            end
            `FN_TRIG_TRG:
            begin
                a_trg = 1'b1;
                b_trg = 1'b1;
            end
            `FN_DIR_CLK:  b_clk = 1'b1;
            `FN_TRIG_CLK:
            begin
                a_trg = 1'b1;
                b_clk = 1'b1;
            end
            `FN_CLK_TRIG:
            begin
                a_clk = 1'b1;
                b_trg = 1'b1;
            end
            `FN_TRIG_GT:
            begin
                a_trg  = 1'b1;
                b_gate = 1'b1;
            end
            default:      a_trg = 1'b0;
        endcase
    end

    // ******************************************************************
    // Direction and external count steps.
    // ******************************************************************

    wire code_updn  = (input_function_code == `FN_CLK_UPDN);
    wire code_discr = (input_function_code == `FN_DISCR);
    // Clock up/down: B steps down and wins over A stepping up.
    wire ud_step    = code_updn & (a_ev | b_ev);
    // Discrimination: B edges count only while A is low.
    wire ds_up      = code_discr & b_rise & ~a_lvl_r;
    wire ds_dn      = code_discr & b_fall & ~a_lvl_r;
    wire step_ev    = ud_step | ds_up | ds_dn;
    wire step_up    = code_updn ? ~b_ev : ds_up;
    reg  dir_up;

    // Direction in use; pin functions take priority over the soft bit.
    always @*
    begin
        case (input_function_code)
            `FN_CLK_UPDN: dir_up = step_ev ? step_up : dir_step_r;
            `FN_DISCR:    dir_up = step_ev ? step_up : dir_step_r;
            `FN_DIR_CLK:  dir_up = a_lvl_r;
            `FN_A_DIR:    dir_up = a_lvl_r;
            `FN_TRIG_DIR: dir_up = dir_trig_r;
            default:      dir_up = soft_direction_bit;
        endcase
    end

    // ******************************************************************
    // Prescaler.
    // ******************************************************************

    // Gate pins hold counting while high.
    wire gate_hold = (a_gate & a_lvl_r) | (b_gate & b_lvl_r);
    wire running   = timer_control_reg[`CT_START] & ~halt_r;
    wire div3_tick = (div3_r == `DIV3_LAST);
    reg  src_ev;

    // Prescaler source: steps, pin clock, cascade or internal clock / 3.
    always @*
    begin
        if (code_updn | code_discr)
            src_ev = step_ev;
        else if (b_clk)
            src_ev = b_ev;
        else if (a_clk)
            src_ev = a_ev;
        else if (cascade_select)
            src_ev = i_cascade_tick;
        else
            src_ev = div3_tick;
    end

    wire src_ok = src_ev & running & ~gate_hold;
    wire tick   = src_ok & (psc_cnt_r == `RST_PSC);

    // ******************************************************************
    // Counter events.
    // ******************************************************************

    wire wr      = psel & penable & pwrite;
    wire wr_ctrl = wr & (paddr == `ADR_CTRL);
    wire wr_flag = wr & (paddr == `ADR_FLAG);
    wire soft0   = wr_flag & pwdata[`FL_SOFT0];
    wire soft1   = wr_flag & pwdata[`FL_SOFT1];
    wire dclr    = wr_ctrl & pwdata[`CT_CLR];
    // Input A acts on register 0; input B captures into register 1 except in bivalue mode.
    wire trig0   = soft0 | (a_trg & a_ev);
    wire trig1   = (soft1 & reg1_capture_select) | (b_trg & b_ev & ~bivalue_select);
    // Reload trigger: masked unless retriggering, or halted at the end of a one-shot count.
    wire rl_ok   = one_shot_select ? (halt_r | retrig) : retrig;
    wire reload0 = trig0 & ~reg0_capture_select & rl_ok;
    wire cap0    = trig0 & reg0_capture_select;
    wire bicap   = bivalue_select & reg0_capture_select;
    wire into0   = cap0 & ~(bicap & sel_r);
    wire into1   = (cap0 & bicap & sel_r) | trig1;
    wire eoc     = tick & (dir_up ? (cnt_r == `CNT_FULL) : (cnt_r == `CNT_ZERO));
    wire free    = bicap | (reg0_capture_select & ~one_shot_select);
    wire match   = tick & (cnt_r == compare_reg_0);
    wire clr     = dclr | (into0 & clear_on_capture) | (match & clear_on_match);
    wire [CW-1:0] cnt_step = dir_up ? cnt_r + 1'b1 : cnt_r - 1'b1;

    // Divide-by-three and prescaler down counter.
    always @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            div3_r          <= 2'h0;
            psc_cnt_r       <= `RST_PSC;
            o_prescale_tick <= 1'b0;
        end
        else
        begin
            div3_r          <= div3_tick ? 2'h0 : div3_r + 1'b1;
            o_prescale_tick <= tick;
            if (clr)
                psc_cnt_r <= psc_val_r;
            else if (tick)
                psc_cnt_r <= psc_val_r;
            else if (src_ok)
                psc_cnt_r <= psc_cnt_r - 1'b1;
        end
    end

    // Counter, one-shot halt, alternation and captures.
    always @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            cnt_r              <= `RST_WORD;
            halt_r             <= 1'b0;
            sel_r              <= 1'b0;
            dir_step_r         <= 1'b1;
            dir_trig_r         <= 1'b1;
            o_end_of_count     <= 1'b0;
            load_capture_reg_0 <= `RST_WORD;
            load_capture_reg_1 <= `RST_WORD;
        end
        else
        begin
            o_end_of_count <= eoc;
            if (step_ev)
                dir_step_r <= step_up;
            // Trigger up/down: B wins over A.
            if ((input_function_code == `FN_TRIG_DIR) & (a_ev | b_ev))
                dir_trig_r <= ~b_ev;
            if (clr)
                cnt_r <= dir_up ? `CNT_ZERO : `CNT_FULL;
            else if (reload0)
            begin
                cnt_r  <= load_capture_reg_0;
                halt_r <= 1'b0;
            end
            else if (eoc & one_shot_select)
                halt_r <= 1'b1;
            else if (eoc & ~free)
                cnt_r <= sel_r ? load_capture_reg_1 : load_capture_reg_0;
            else if (tick)
                cnt_r <= cnt_step;
            if (wr_ctrl & ~(eoc & one_shot_select & ~clr & ~reload0))
                halt_r <= 1'b0;
            // Bivalue low holds register 0 as current.
            if (!bivalue_select)
                sel_r <= 1'b0;
            else if (reload0)
                sel_r <= 1'b1;
            else if (eoc & ~one_shot_select & ~free & ~clr)
                sel_r <= ~sel_r;
            else if (cap0 & bicap)
                sel_r <= ~sel_r;
            if (into0)
                load_capture_reg_0 <= cnt_r;
            else if (wr & (paddr == `ADR_LC0))
                load_capture_reg_0 <= pwdata[CW-1:0];
            if (into1)
                load_capture_reg_1 <= cnt_r;
            else if (~reg1_capture_select & ~bivalue_select)
                load_capture_reg_1 <= cnt_r;
            else if (wr & (paddr == `ADR_LC1))
                load_capture_reg_1 <= pwdata[CW-1:0];
        end
    end

    // ******************************************************************
    // Register bus slave.
    // ******************************************************************

    reg mapped;

    // Address decode of the register map.
    always @*
    begin
        case (paddr)
            `ADR_CTRL:  mapped = 1'b1;
            `ADR_MODE:  mapped = 1'b1;
            `ADR_FLAG:  mapped = 1'b1;
            `ADR_INCTL: mapped = 1'b1;
            `ADR_LC0:   mapped = 1'b1;
            `ADR_LC1:   mapped = 1'b1;
            `ADR_CMP0:  mapped = 1'b1;
            `ADR_PSC:   mapped = 1'b1;
            `ADR_COUNT: mapped = 1'b1;
            default:    mapped = 1'b0;
        endcase
    end

    // Zero wait states; unmapped addresses answer with an error.
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    // Software writes; the clear bit is a command and is not stored.
    always @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            timer_control_reg <= `RST_CTRL;
            timer_mode_reg    <= `RST_MODE;
            input_control_reg <= `RST_INCTL;
            compare_reg_0     <= `RST_WORD;
            psc_val_r         <= `RST_PSC;
        end
        else if (wr)
        begin
            case (paddr)
                `ADR_CTRL:  timer_control_reg <= pwdata[7:0] & 8'h1b;
                `ADR_MODE:  timer_mode_reg    <= pwdata[7:0] & 8'h3f;
                `ADR_INCTL: input_control_reg <= pwdata[7:0];
                `ADR_CMP0:  compare_reg_0     <= pwdata[CW-1:0];
                `ADR_PSC:   psc_val_r         <= pwdata[PW-1:0];
                default:    psc_val_r         <= psc_val_r;
            endcase
        end
    end

    // Read data is latched in the setup phase and stands through the access.
    always @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            prdata  <= 32'h0;
            o_count <= `RST_WORD;
        end
        else
        begin
            o_count <= cnt_r;
            if (psel & ~penable)
            begin
                case (paddr)
                    `ADR_CTRL:  prdata <= {24'h0, timer_control_reg[7:7], running,
                                           dir_up, timer_control_reg[4:0]};
                    `ADR_MODE:  prdata <= {24'h0, timer_mode_reg};
                    `ADR_INCTL: prdata <= {24'h0, input_control_reg};
                    `ADR_LC0:   prdata <= {16'h0, load_capture_reg_0};
                    `ADR_LC1:   prdata <= {16'h0, load_capture_reg_1};
                    `ADR_CMP0:  prdata <= {16'h0, compare_reg_0};
                    `ADR_PSC:   prdata <= {24'h0, psc_val_r};
                    `ADR_COUNT: prdata <= {16'h0, cnt_r};
                    default:    prdata <= 32'h0;
                endcase
            end
        end
    end

endmodule

//--- bench/mft_pin_src.sv
// Behavioural source for the two timer input pins.
`timescale 1ns/100ps
module mft_pin_src (
    // Clock.
    input  wire i_sys_clk,
    // Pin levels.
    output reg  o_pin_a,
    output reg  o_pin_b
);
    // Both pins idle low until a test moves them.
    initial
    begin
        o_pin_a = 1'b0;
        o_pin_b = 1'b0;
    end
    // Moves the pins after an edge and holds them two prescaler periods.
    task drive(input logic a, input logic b);
        @(posedge i_sys_clk);
        o_pin_a <= a;
        o_pin_b <= b;
        repeat (6) @(posedge i_sys_clk);
    endtask
endmodule

//--- bench/mft_core_chk.sv
// Port checker for the timer core, bound to it.
`timescale 1ns/100ps
`include "mft_regs.vh"
module mft_core_chk #(
    parameter CW = 16,
    parameter PW = 8
) (
    // Clock and reset.
    input wire          i_sys_clk,
    input wire          i_rst_n,
    // Register bus.
    input wire          psel,
    input wire          penable,
    input wire          pwrite,
    input wire [7:0]    paddr,
    input wire [31:0]   pwdata,
    input wire [31:0]   prdata,
    input wire          pready,
    input wire          pslverr,
    // Timer state.
    input wire          o_prescale_tick,
    input wire [CW-1:0] o_count,
    input wire          o_end_of_count
);
    // ****************************************
    // Bus decode and timing checks.
    // ****************************************
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rst_n);
    // Access phase and the set of mapped words.
    wire acc    = psel && penable;
    wire mapped = (paddr <= `ADR_COUNT) && (paddr[1:0] == 2'b00);
    wire clr    = acc && pwrite && (paddr == `ADR_CTRL) && pwdata[2];
    AST_PREADY: assert property (acc |-> pready)
        else $error("access phase without ready");
    AST_UNMAPPED: assert property (acc |-> (pslverr == !mapped))
        else $error("error response disagrees with address");
    AST_FLAG_RD: assert property (acc && !pwrite && paddr == `ADR_FLAG |-> prdata == 32'h0)
        else $error("flag register read not zero");
    AST_CNT_RD: assert property (acc && !pwrite && paddr == `ADR_COUNT |-> prdata[31:16] == 16'h0
        && (prdata[15:0] == o_count || prdata[15:0] == $past(o_count)))
        else $error("count read disagrees with count output");
    AST_CLR_UP: assert property (clr && pwdata[1] |-> ##[1:2] o_count == `CNT_ZERO)
        else $error("clear counting up not zero");
    AST_CLR_DN: assert property (clr && !pwdata[1] |-> ##[1:2] o_count == `CNT_FULL)
        else $error("clear counting down not full");
    AST_TICK: assert property (o_prescale_tick |=> (!o_prescale_tick) [*2])
        else $error("prescaler ticks closer than three cycles");
    AST_EOC: assert property (o_end_of_count |=> !o_end_of_count)
        else $error("end of count longer than one cycle");
endmodule
bind mft_core mft_core_chk #(.CW(CW), .PW(PW)) chk (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .o_prescale_tick(o_prescale_tick), .o_count(o_count),
    .o_end_of_count(o_end_of_count));

//--- bench/multifunction_timer_modes_inputs_tb_top.sv
// Register-level bench for the timer core with a pin source.
`timescale 1ns/100ps
`include "mft_regs.vh"
module multifunction_timer_modes_inputs_tb_top;
    logic        i_sys_clk;
    logic        i_rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        i_cascade_tick = 1'b0;
    wire  [31:0] prdata;
    wire         pready;
    wire         pslverr;
    wire         pin_a;
    wire         pin_b;
    wire         tick;
    wire  [15:0] count;
    wire         eoc;
    int          failures = 0;
    int          cmp_count = 0;
    int          cyc = 0;
    int          eoc_seen = 0;
    int          base;
    logic        err;
    logic [15:0] lo;
    logic [31:0] v;
    logic [31:0] w;
    logic [31:0] e;
    logic [7:0]  rst_adr [8] = '{`ADR_MODE, `ADR_FLAG, `ADR_INCTL, `ADR_LC0,
                                 `ADR_LC1, `ADR_CMP0, `ADR_PSC, `ADR_COUNT};
    mft_core dut (
        .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .i_timer_input_a(pin_a), .i_timer_input_b(pin_b),
        .i_cascade_tick(i_cascade_tick), .o_prescale_tick(tick), .o_count(count),
        .o_end_of_count(eoc));
    mft_pin_src pins (.i_sys_clk(i_sys_clk), .o_pin_a(pin_a), .o_pin_b(pin_b));
    // ****************************************
    // Clock, watchdog and bus tasks.
    // ****************************************
    initial
    begin
        i_sys_clk = 1'b0;
        forever #20 i_sys_clk = ~i_sys_clk;
    end
    // Counts cycles and end-of-count pulses; a hang ends the run.
    always @(posedge i_sys_clk)
    begin
        cyc <= cyc + 1;
        if (eoc === 1'b1)
            eoc_seen <= eoc_seen + 1;
        if (cyc == 20000)
        begin
            failures = failures + 1;
            report_and_stop;
        end
    end
    // One bus transfer; read data and error are taken when ready is seen.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge i_sys_clk);
        penable <= 1'b1;
        @(posedge i_sys_clk);
        while (pready !== 1'b1)
            @(posedge i_sys_clk);
        v = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge i_sys_clk);
    endtask
    // Range compare; an unknown never passes.
    task automatic chk(input logic [31:0] g, l, h, input string m);
        cmp_count++;
        if (((g >= l) && (g <= h)) !== 1'b1)
        begin
            failures++;
            $display("MISMATCH at %0t: %s got %h", $time, m, g);
        end
    endtask
    task automatic tdone(input string n);
        $display("test %s done, mismatches so far %0d", n, failures);
    endtask
    task report_and_stop;
        $display("comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // ****************************************
    // Test sequence.
    // ****************************************
    initial
    begin
        repeat (12) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        foreach (rst_adr[i])
        begin
            rd(rst_adr[i]);
            chk(v, 32'h0, 32'h0, "reset value");
        end
        rd(8'h24);
        chk({31'h0, err}, 32'h1, 32'h1, "unmapped error");
        tdone("reset");
        for (int d = 0; d < 2; d++)
        begin
            wr(`ADR_CTRL, d ? 32'h2 : 32'h0);
            wr(`ADR_CTRL, d ? 32'h6 : 32'h4);
            rd(`ADR_COUNT);
            chk(v, d ? 32'h0 : 32'hffff, d ? 32'h0 : 32'hffff, "clear");
            rd(`ADR_CTRL);
            chk(v & 32'h24, d ? 32'h20 : 32'h0, d ? 32'h20 : 32'h0, "status");
        end
        tdone("clear");
        for (int i = 0; i < 2; i++)
        begin
            e = i ? 32'h1e : 32'ha;
            wr(`ADR_PSC, i ? 32'h0 : 32'h2);
            wr(`ADR_CTRL, 32'h2);
            wr(`ADR_CTRL, 32'h6);
            wr(`ADR_CTRL, 32'h3);
            wt(87);
            wr(`ADR_CTRL, 32'h2);
            rd(`ADR_COUNT);
            chk(v, e - 32'h1, e + 32'h1, "rate");
        end
        tdone("prescaler");
        base = eoc_seen;
        wr(`ADR_MODE, 32'h3);
        wr(`ADR_LC0, 32'hfff0);
        wr(`ADR_CTRL, 32'h3);
        wr(`ADR_FLAG, 32'h1);
        rd(`ADR_COUNT);
        chk(v, 32'hfff0, 32'hfff2, "retrigger");
        wr(`ADR_MODE, 32'h1);
        wt(150);
        rd(`ADR_COUNT);
        w = v;
        wt(30);
        rd(`ADR_COUNT);
        chk(v, w, w, "halted");
        chk(32'(eoc_seen - base), 32'h1, 32'h1, "end count");
        wr(`ADR_FLAG, 32'h1);
        rd(`ADR_COUNT);
        chk(v, 32'hfff0, 32'hfff2, "restart");
        wt(12);
        wr(`ADR_FLAG, 32'h1);
        rd(`ADR_COUNT);
        chk(v, 32'hfff4, 32'hfff9, "masked");
        tdone("one shot");
        for (int i = 0; i < 2; i++)
        begin
            wr(`ADR_MODE, i ? 32'h12 : 32'h2);
            wr(i ? `ADR_LC1 : `ADR_LC0, i ? 32'hfff0 : 32'hfff8);
            wr(`ADR_FLAG, 32'h1);
            wt(6);
            lo = 16'hffff;
            repeat (150)
            begin
                @(posedge i_sys_clk);
                if (count < lo)
                    lo = count;
            end
            chk({16'h0, lo}, i ? 32'hfff0 : 32'hfff8, i ? 32'hfff0 : 32'hfff8, "lowest");
        end
        tdone("reload");
        wr(`ADR_CTRL, 32'h2);
        wr(`ADR_MODE, 32'h0);
        rd(`ADR_COUNT);
        w = v;
        rd(`ADR_LC1);
        chk(v, w, w, "monitor");
        wr(`ADR_MODE, 32'h4);
        wr(`ADR_FLAG, 32'h1);
        rd(`ADR_LC0);
        chk(v, w, w, "soft capture");
        wr(`ADR_INCTL, 32'h14);
        for (int i = 0; i < 2; i++)
        begin
            wr(`ADR_MODE, i ? 32'h18 : 32'h8);
            wr(`ADR_LC1, 32'h1234);
            pins.drive(1'b0, 1'b1);
            pins.drive(1'b0, 1'b0);
            rd(`ADR_LC1);
            chk(v, i ? 32'h1234 : w, i ? 32'h1234 : w, "pin capture");
        end
        tdone("capture");
        wr(`ADR_MODE, 32'h0);
        pins.drive(1'b1, 1'b0);
        wr(`ADR_INCTL, 32'h20);
        wr(`ADR_CTRL, 32'h6);
        wr(`ADR_CTRL, 32'h3);
        for (int i = 0; i < 2; i++)
        begin
            rd(`ADR_COUNT);
            w = v;
            wt(30);
            rd(`ADR_COUNT);
            chk(v - w, i ? 32'h9 : 32'h0, i ? 32'hc : 32'h0, "gate");
            pins.drive(1'b0, 1'b0);
        end
        wr(`ADR_INCTL, 32'hb0);
        for (int i = 0; i < 2; i++)
        begin
            pins.drive(!i, 1'b0);
            rd(`ADR_CTRL);
            chk(v & 32'h20, i ? 32'h0 : 32'h20, i ? 32'h0 : 32'h20, "pin direction");
        end
        tdone("pins");
        wr(`ADR_CTRL, 32'h2);
        for (int i = 0; i < 16; i++)
        begin
            wr(`ADR_INCTL, {24'h0, i[3:0], 4'h5});
            rd(`ADR_INCTL);
            chk(v, {24'h0, i[3:0], 4'h5}, {24'h0, i[3:0], 4'h5}, "code");
        end
        wr(`ADR_INCTL, 32'h0);
        wr(`ADR_CTRL, 32'h6);
        wr(`ADR_MODE, 32'h14);
        wr(`ADR_CTRL, 32'hb);
        repeat (2)
        begin
            wt(30);
            wr(`ADR_FLAG, 32'h1);
        end
        rd(`ADR_LC0);
        chk(v, 32'h9, 32'hc, "bicapture 0");
        rd(`ADR_LC1);
        chk(v, 32'h9, 32'hc, "bicapture 1");
        wr(`ADR_MODE, 32'h4);
        wr(`ADR_CTRL, 32'h0);
        wr(`ADR_CTRL, 32'h4);
        wr(`ADR_CTRL, 32'h3);
        wt(6);
        rd(`ADR_COUNT);
        chk(v, 32'h0, 32'h2, "free run");
        wr(`ADR_MODE, 32'h0);
        wr(`ADR_LC0, 32'h8000);
        wr(`ADR_FLAG, 32'h1);
        rd(`ADR_COUNT);
        chk(v, 32'h0, 32'h9, "no reload");
        tdone("modes");
        wr(`ADR_MODE, 32'h20);
        wr(`ADR_CTRL, 32'h6);
        wr(`ADR_CTRL, 32'h3);
        repeat (5)
        begin
            @(posedge i_sys_clk);
            i_cascade_tick <= 1'b1;
            @(posedge i_sys_clk);
            i_cascade_tick <= 1'b0;
            wt(2);
        end
        wt(4);
        wr(`ADR_CTRL, 32'h2);
        rd(`ADR_COUNT);
        chk(v, 32'h5, 32'h5, "cascade");
        tdone("cascade");
        report_and_stop;
    end
endmodule
